/* hdl/adc_cfg_pkg.sv */
package adc_cfg_pkg;
    // Sample word layout: {flag_b, flag_a, chan_b[13:0], chan_a[13:0]}
    localparam int SAMPLE_W = 14;
    localparam int PAIRS = 7;
    localparam int WORD_W = 30;
    localparam int FLAG_A_POS = 28;
    localparam int FLAG_B_POS = 29;
    // Conversion pipeline and output timing
    localparam int PIPE_LAT = 6;
    localparam int HALF_CYC = 2;
    // Mode control registers reached over the serial port
    localparam int MODE_REGS = 5;
    localparam logic [6:0] MREG_SLEEP = 7'h01;
    localparam logic [6:0] MREG_DCS = 7'h02;
    localparam logic [6:0] MREG_DRIVE = 7'h03;
    localparam logic [7:0] MREG_RST = 8'h00;
    localparam logic [2:0] DRIVE_3P5MA = 3'h0;
    localparam logic [2:0] DRIVE_1P75MA = 3'h1;
    // Serial frame: rw bit, 7 address bits, 8 data bits
    localparam logic [3:0] ADDR_LAST = 4'h7;
    localparam logic [3:0] DATA_FIRST = 4'h8;
    localparam logic [3:0] FRAME_LAST = 4'hf;
    // Synchroniser lanes
    localparam int PIN_CS = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SDI = 2;
    localparam int PIN_MODE = 3;
    localparam int PIN_ENCP = 4;
    localparam int PIN_ENCN = 5;
    localparam int PINS = 6;
    localparam logic [1:0] STRAP_DONE = 2'h3;
    // Wishbone register map
    localparam logic [7:0] WB_CTRL = 8'h00;
    localparam logic [7:0] WB_STATUS = 8'h04;
    localparam logic [7:0] WB_COUNT = 8'h08;
    localparam int CTRL_RUN = 0;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam int ST_PAR = 0;
    localparam int ST_SLEEP = 1;
    localparam int ST_DCS = 2;
    localparam int ST_DRIVE = 4;
    localparam int ST_LOST = 8;

    typedef enum logic [1:0] {
        SPI_CMD = 2'b00,
        SPI_DATA = 2'b01,
        SPI_DONE = 2'b10
    } spi_state_t;

    typedef enum logic [1:0] {
        OUT_IDLE = 2'b00,
        OUT_LOW = 2'b01,
        OUT_HIGH = 2'b10
    } out_state_t;
endpackage

/* hdl/adc_cfg_if.sv */
`timescale 1ns/100ps
// Port of the mode register file, with live control taps
interface mode_mem_if;
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [2:0] drive;
    logic sleep;
    logic dcs;
    modport ctl(output we, addr, wdata, input rdata, drive, sleep, dcs);
    modport mem(input we, addr, wdata, output rdata, drive, sleep, dcs);
endinterface

// Valid/ready word stream
interface word_stream_if #(parameter int W = 30);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, data, input ready);
    modport snk(input valid, data, output ready);
endinterface

/* hdl/mode_reg_file.sv */
`timescale 1ns/100ps
module mode_reg_file (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    mode_mem_if.mem port
);
    import adc_cfg_pkg::*;

    typedef struct packed {
        logic [MODE_REGS-1:0][7:0] r;
        logic [7:0] rdata;
    } st_t;

    st_t q;
    st_t n;

    // Write and registered read; addresses past the file read zero
    always_comb begin
        n = q;
        n.rdata = 8'h00;
        for (int i = 0; i < MODE_REGS; i++) begin
            if (port.addr == 7'(i)) begin
                n.rdata = q.r[i];
                if (port.we) begin
                    n.r[i] = port.wdata;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{r: '{default: MREG_RST}, rdata: 8'h00};
        end else begin
            q <= n;
        end
    end

    // Live taps steering the converter
    assign port.rdata = q.rdata;
    assign port.sleep = q.r[MREG_SLEEP][0];
    assign port.dcs = q.r[MREG_DCS][0];
    assign port.drive = q.r[MREG_DRIVE][2:0];
endmodule

/* hdl/two_entry_buf.sv */
`timescale 1ns/100ps
module two_entry_buf #(
    parameter int W = 30
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill and drain sides
    word_stream_if.snk wr,
    word_stream_if.src rd
);
    if (W < 1) $error("two_entry_buf: width must be positive");

    typedef struct packed {
        logic [1:0][W-1:0] e;
        logic head;
        logic [1:0] cnt;
    } st_t;

    st_t q;
    st_t n;
    logic push;
    logic pop;

    // Tail slot is head when empty, the other slot when one is held
    always_comb begin
        n = q;
        push = wr.valid && (q.cnt != 2'd2);
        pop = rd.ready && (q.cnt != 2'd0);
        if (push) begin
            n.e[q.head ^ q.cnt[0]] = wr.data;
        end
        if (pop) begin
            n.head = ~q.head;
        end
        n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign wr.ready = (q.cnt != 2'd2);
    assign rd.valid = (q.cnt != 2'd0);
    assign rd.data = q.e[q.head];
endmodule

/* hdl/adc_mode_config_port.sv */
`timescale 1ns/100ps
// Functional notes
// - A conversion starts on the rising edge of the positive encode input, the falling edge of its complement.
// - In serial mode each SDI bit is taken into the shift path on the rising SCK edge.
// - In serial mode the mode register contents are read back on SDO.
// - Shifting on SCK happens only while CS is low, and the host keeps CS low for the whole frame.
// - SDO only ever pulls low; the high level comes from an outside pull-up.
// - With the mode select pin low, CS, SCK, SDI and SDO form a serial port controlling all modes.
// - With the mode select pin high, CS, SCK and SDI are static levels controlling a reduced mode set.
// - In parallel mode SDI picks 3.5mA or 1.75mA output drive.
// - In parallel mode SCK can put the device to sleep.
// - In parallel mode CS turns the encode duty-cycle stabilizer on or off.
// - Each output pair carries even bits while the output clock is low and odd bits while it is high.
// - Both channel overrange flags share one output, high when an overrange occurred.
module adc_mode_config_port #(
    parameter int LATENCY = adc_cfg_pkg::PIPE_LAT,
    parameter int HALF = adc_cfg_pkg::HALF_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Configuration pins
    input wire logic programming_mode_select_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    // Encode clock pins
    input wire logic encode_clock_pos_i,
    input wire logic encode_clock_neg_i,
    // Converter core results
    input wire logic [adc_cfg_pkg::SAMPLE_W-1:0] sample_a_i,
    input wire logic [adc_cfg_pkg::SAMPLE_W-1:0] sample_b_i,
    input wire logic overrange_a_i,
    input wire logic overrange_b_i,
    // Data outputs
    output logic data_output_clock_o,
    output logic [adc_cfg_pkg::PAIRS-1:0] chan_a_ddr_pair_o,
    output logic [adc_cfg_pkg::PAIRS-1:0] chan_b_ddr_pair_o,
    output logic overrange_flag_o,
    // Effective mode controls
    output logic [2:0] drive_code_o,
    output logic sleep_o,
    output logic dcs_en_o
);
    import adc_cfg_pkg::*;

    if (LATENCY < 1 || LATENCY > 16) $error("adc_mode_config_port: LATENCY out of range");
    if (HALF < 1 || HALF > 15) $error("adc_mode_config_port: HALF out of range");

    typedef struct packed {
        logic [PINS-1:0] sync1;
        logic [PINS-1:0] sync2;
        logic [PINS-1:0] prev;
        logic [1:0] strap_cnt;
        logic par_mode;
        spi_state_t spi;
        logic [3:0] bitcnt;
        logic [15:0] sr;
        logic rd;
        logic [7:0] dsr;
        logic sdo_oe;
        logic mem_we;
        logic [6:0] mem_addr;
        logic [7:0] mem_wdata;
        logic [LATENCY-1:0][WORD_W-1:0] pipe;
        logic [LATENCY-1:0] pipe_v;
        logic pend;
        logic [WORD_W-1:0] pend_word;
        logic lost;
        out_state_t ost;
        logic [3:0] hcnt;
        logic [WORD_W-1:0] oword;
        logic out_clk;
        logic [PAIRS-1:0] da;
        logic [PAIRS-1:0] db;
        logic ofl;
        logic [2:0] drive;
        logic sleep;
        logic dcs;
        logic run;
        logic ack;
        logic [31:0] dat;
        logic [31:0] sent;
    } state_t;

    state_t q;
    state_t n;

    mode_mem_if mem_if();
    word_stream_if #(.W(WORD_W)) fill_if();
    word_stream_if #(.W(WORD_W)) drain_if();

    mode_reg_file u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .port(mem_if.mem)
    );

    two_entry_buf #(.W(WORD_W)) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr(fill_if.snk),
        .rd(drain_if.src)
    );

    // Pick the even or odd half of a 14-bit sample
    function automatic logic [PAIRS-1:0] pick(input logic [SAMPLE_W-1:0] v, input logic odd);
        logic [PAIRS-1:0] r;
        r = '0;
        for (int i = 0; i < PAIRS; i++) begin
            r[i] = v[2*i + int'(odd)];
        end
        return r;
    endfunction

    logic sck_rise;
    logic sck_fall;
    logic enc_rise;
    logic serial;
    logic sdo_bit;
    logic [31:0] status;

    // Edge detection works only on the second synchroniser stage
    assign sck_rise = q.sync2[PIN_SCK] && !q.prev[PIN_SCK];
    assign sck_fall = !q.sync2[PIN_SCK] && q.prev[PIN_SCK];
    assign enc_rise = (q.sync2[PIN_ENCP] && !q.sync2[PIN_ENCN]) && !(q.prev[PIN_ENCP] && !q.prev[PIN_ENCN]);
    assign serial = !q.par_mode && (q.strap_cnt == STRAP_DONE);

    // Status word for software
    always_comb begin
        status = 32'h0000_0000;
        status[ST_PAR] = q.par_mode;
        status[ST_SLEEP] = q.sleep;
        status[ST_DCS] = q.dcs;
        status[ST_DRIVE +: 3] = q.drive;
        status[ST_LOST] = q.lost;
    end

    // Next state of the whole block
    always_comb begin
        n = q;
        sdo_bit = 1'b1;
        n.sync1 = {encode_clock_neg_i, encode_clock_pos_i, programming_mode_select_i, sdi_i, sck_i, cs_n_i};
        n.sync2 = q.sync1;
        n.prev = q.sync2;
        n.mem_we = 1'b0;
        n.ack = 1'b0;

        // Mode strap is caught once, after the synchroniser has filled
        if (q.strap_cnt != STRAP_DONE) begin
            n.strap_cnt = q.strap_cnt + 2'd1;
            n.par_mode = q.sync2[PIN_MODE];
        end

        // Serial frame; a frame cut short by CS never writes
        if (!serial || q.sync2[PIN_CS]) begin
            n.spi = SPI_CMD;
            n.bitcnt = 4'h0;
            n.rd = 1'b0;
            n.sdo_oe = 1'b0;
        end else begin
            if (sck_rise && q.spi != SPI_DONE) begin
                n.sr = {q.sr[14:0], q.sync2[PIN_SDI]};
                n.bitcnt = q.bitcnt + 4'd1;
                if (q.bitcnt == ADDR_LAST) begin
                    n.rd = n.sr[7];
                    n.mem_addr = n.sr[6:0];
                    n.spi = SPI_DATA;
                end
                if (q.bitcnt == FRAME_LAST) begin
                    n.mem_we = !q.rd;
                    n.mem_wdata = n.sr[7:0];
                    n.spi = SPI_DONE;
                end
            end
            // Readback shifts out on falling edges, for the host to take a falling edge later
            if (sck_fall && q.rd) begin
                if (q.spi == SPI_DATA && q.bitcnt == DATA_FIRST) begin
                    sdo_bit = mem_if.rdata[7];
                    n.dsr = {mem_if.rdata[6:0], 1'b0};
                end else begin
                    sdo_bit = q.dsr[7];
                    n.dsr = {q.dsr[6:0], 1'b0};
                end
                // Pull low for a zero, release for a one
                n.sdo_oe = (q.spi == SPI_DATA) && !sdo_bit;
            end
        end

        // Effective controls from pins or from the mode registers
        if (q.par_mode) begin
            n.drive = q.sync2[PIN_SDI] ? DRIVE_1P75MA : DRIVE_3P5MA;
            n.sleep = q.sync2[PIN_SCK];
            n.dcs = q.sync2[PIN_CS];
        end else begin
            n.drive = mem_if.drive;
            n.sleep = mem_if.sleep;
            n.dcs = mem_if.dcs;
        end

        // Wishbone: one-cycle answer, unmapped reads zero
        if (wb_cyc_i && wb_stb_i && !q.ack) begin
            n.ack = 1'b1;
            n.dat = 32'h0000_0000;
            unique case (wb_adr_i)
                WB_CTRL: begin
                    n.dat[CTRL_RUN] = q.run;
                    if (wb_we_i && wb_sel_i[0]) begin
                        n.run = wb_dat_i[CTRL_RUN];
                    end
                end
                WB_STATUS: begin
                    n.dat = status;
                    if (wb_we_i && wb_sel_i[1] && wb_dat_i[ST_LOST]) begin
                        n.lost = 1'b0;
                    end
                end
                WB_COUNT: n.dat = q.sent;
                default: n.dat = 32'h0000_0000;
            endcase
        end

        // Hand the pending word to the buffer
        if (q.pend && fill_if.ready) begin
            n.pend = 1'b0;
        end

        // Sample on each encode edge while not asleep; a full pipeline slot leaves after LATENCY edges
        if (enc_rise && !q.sleep) begin
            n.pipe[0] = {overrange_b_i, overrange_a_i, sample_b_i, sample_a_i};
            n.pipe_v[0] = 1'b1;
            for (int i = 1; i < LATENCY; i++) begin
                n.pipe[i] = q.pipe[i-1];
                n.pipe_v[i] = q.pipe_v[i-1];
            end
            if (q.pipe_v[LATENCY-1]) begin
                // Set wins over a software clear in the same cycle
                if (q.pend && !fill_if.ready) begin
                    n.lost = 1'b1;
                end
                n.pend = 1'b1;
                n.pend_word = q.pipe[LATENCY-1];
            end
        end

        // Output serialiser; stalls while run is off so the buffer backs up
        unique case (q.ost)
            OUT_IDLE: begin
                if (drain_if.valid && q.run) begin
                    n.oword = drain_if.data;
                    n.ost = OUT_LOW;
                    n.hcnt = 4'h0;
                    n.out_clk = 1'b0;
                    n.da = pick(drain_if.data[SAMPLE_W-1:0], 1'b0);
                    n.db = pick(drain_if.data[2*SAMPLE_W-1:SAMPLE_W], 1'b0);
                    n.ofl = drain_if.data[FLAG_A_POS];
                    n.sent = q.sent + 32'd1;
                end
            end
            OUT_LOW: begin
                if (q.hcnt == 4'(HALF - 1)) begin
                    n.ost = OUT_HIGH;
                    n.hcnt = 4'h0;
                    n.out_clk = 1'b1;
                    n.da = pick(q.oword[SAMPLE_W-1:0], 1'b1);
                    n.db = pick(q.oword[2*SAMPLE_W-1:SAMPLE_W], 1'b1);
                    n.ofl = q.oword[FLAG_B_POS];
                end else begin
                    n.hcnt = q.hcnt + 4'd1;
                end
            end
            OUT_HIGH: begin
                if (q.hcnt == 4'(HALF - 1)) begin
                    n.ost = OUT_IDLE;
                end else begin
                    n.hcnt = q.hcnt + 4'd1;
                end
            end
            default: n.ost = OUT_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.run <= CTRL_RUN_RST;
        end else begin
            q <= n;
        end
    end

    // Buffer and register file hookup
    assign fill_if.valid = q.pend;
    assign fill_if.data = q.pend_word;
    assign drain_if.ready = (q.ost == OUT_IDLE) && q.run;
    assign mem_if.we = q.mem_we;
    assign mem_if.addr = q.mem_addr;
    assign mem_if.wdata = q.mem_wdata;

    // Outputs, all from the state register; SDO data is a fixed low
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign sdo_o = 1'b0;
    assign sdo_oe_o = q.sdo_oe;
    assign data_output_clock_o = q.out_clk;
    assign chan_a_ddr_pair_o = q.da;
    assign chan_b_ddr_pair_o = q.db;
    assign overrange_flag_o = q.ofl;
    assign drive_code_o = q.drive;
    assign sleep_o = q.sleep;
    assign dcs_en_o = q.dcs;
endmodule

/* verification/adc_mode_config_port_properties.sv */
`timescale 1ns/100ps
module adc_mode_config_port_properties
    import adc_cfg_pkg::*;
#(
    parameter int LATENCY = PIPE_LAT,
    parameter int HALF = HALF_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Configuration pins
    input wire logic programming_mode_select_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    // Watched outputs
    input wire logic data_output_clock_o,
    input wire logic [2:0] drive_code_o,
    input wire logic sleep_o,
    input wire logic dcs_en_o
);
    logic [3:0] settle_reg;
    logic settled;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Strap capture and pin synchronisers need a few cycles after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_reg <= 4'h0;
        end else if (settle_reg != 4'hf) begin
            settle_reg <= settle_reg + 4'h1;
        end
    end
    assign settled = settle_reg == 4'hf;
    // Building blocks
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Clock holds high through the odd half and the idle slot, then stays until the next word
    sequence high_half;
        data_output_clock_o ##1 data_output_clock_o;
    endsequence
    sequence par_steady(sig);
        (settled && programming_mode_select_i && $stable(sig))[*8];
    endsequence
    ack_latency_a: assert property (wb_req |=> wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    sdo_low_a: assert property (sdo_o == 1'b0) else $error("sdo driven high");
    sdo_cs_gate_a: assert property (sdo_oe_o |-> !$past(cs_n_i, 3)) else $error("sdo pulled after deselect");
    par_sdo_off_a: assert property (settled && programming_mode_select_i |-> !sdo_oe_o)
        else $error("sdo pulled in parallel mode");
    par_dcs_a: assert property (par_steady(cs_n_i) |-> dcs_en_o == cs_n_i) else $error("dcs level");
    par_sleep_a: assert property (par_steady(sck_i) |-> sleep_o == sck_i) else $error("sleep level");
    par_drive_a: assert property (par_steady(sdi_i) |->
        drive_code_o == (sdi_i ? DRIVE_1P75MA : DRIVE_3P5MA)) else $error("drive level");
    cs_release_a: assert property ((settled && cs_n_i)[*5] |-> !sdo_oe_o) else $error("sdo held");
    clk_high_half_a: assert property ($rose(data_output_clock_o) |=> high_half) else $error("high half");
    clk_low_half_a: assert property ($rose(data_output_clock_o) |->
        !$past(data_output_clock_o, 2)) else $error("low half");
endmodule

bind adc_mode_config_port adc_mode_config_port_properties #(.LATENCY(LATENCY), .HALF(HALF)) chk_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .programming_mode_select_i, .cs_n_i, .sck_i,
    .sdi_i, .sdo_o, .sdo_oe_o, .data_output_clock_o, .drive_code_o, .sleep_o, .dcs_en_o);

/* verification/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
    // Clock and resolved readback wire
    input wire logic clk_i,
    input wire logic sdo_line_i,
    // Port pins
    output logic cs_n_o,
    output logic sck_o,
    output logic sdi_o
);
    // Idle: deselected, clock parked low
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        sdi_o = 1'b0;
    end
    // Frame of nb bits MSB first; 160 ns serial clock, slow enough to sync
    task automatic xfer(input logic [15:0] frm, input int nb, output logic [7:0] rd);
        int i;
        rd = 8'h00;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (i = 0; i < nb; i++) begin
            sdi_o <= frm[15-i];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            // Latch at the fall, value shown since the previous fall
            if (i >= 8) rd = {rd[6:0], sdo_line_i};
            sck_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        sdi_o <= ~frm[16-nb]; // Stale data never looks valid
        cs_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
    // Static levels for parallel mode
    task automatic set_levels(input logic c, input logic k, input logic d);
        @(posedge clk_i);
        cs_n_o <= c;
        sck_o <= k;
        sdi_o <= d;
    endtask
endmodule

/* verification/adc_mode_config_port_tb_top.sv */
`timescale 1ns/100ps
module adc_mode_config_port_tb_top;
    import adc_cfg_pkg::*;
    // Design pins
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, sdo_o, sdo_oe_o, data_output_clock_o, overrange_flag_o, sleep_o, dcs_en_o;
    logic programming_mode_select_i = 1'b0, cs_n_i, sck_i, sdi_i, sdo_line;
    logic encode_clock_pos_i = 1'b0, encode_clock_neg_i = 1'b1, enc_run = 1'b0;
    logic [13:0] sample_a_i = 14'h1555, sample_b_i = 14'h2aaa; // Alternating bits expose swaps
    logic overrange_a_i = 1'b1, overrange_b_i = 1'b0;
    logic [6:0] chan_a_ddr_pair_o, chan_b_ddr_pair_o;
    logic [2:0] drive_code_o;
    int enc_edges = 0, cyc = 0, bad_count = 0, n_tests = 0;

    adc_mode_config_port #(.LATENCY(PIPE_LAT), .HALF(HALF_CYC)) dut_u (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .programming_mode_select_i, .cs_n_i, .sck_i, .sdi_i, .sdo_o, .sdo_oe_o,
        .encode_clock_pos_i, .encode_clock_neg_i, .sample_a_i, .sample_b_i, .overrange_a_i,
        .overrange_b_i, .data_output_clock_o, .chan_a_ddr_pair_o, .chan_b_ddr_pair_o,
        .overrange_flag_o, .drive_code_o, .sleep_o, .dcs_en_o);
    spi_host_model host_u (.clk_i, .sdo_line_i(sdo_line), .cs_n_o(cs_n_i), .sck_o(sck_i), .sdi_o(sdi_i));
    assign sdo_line = sdo_oe_o ? sdo_o : 1'b1;

    always #10 clk_i = ~clk_i;
    // Encode clock, 320 ns, complementary pair; counts rising edges
    always @(posedge clk_i) begin
        if (enc_run && cyc % 8 == 0) begin
            encode_clock_pos_i <= ~encode_clock_pos_i;
            encode_clock_neg_i <= encode_clock_pos_i;
            enc_edges <= enc_edges + int'(!encode_clock_pos_i);
        end
    end
    // Hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [3:0] sel,
        input logic [31:0] d, output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && t < 50) begin
            @(posedge clk_i);
            t++;
        end
        if (t == 50) bad_count++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic test_regs;
        logic [31:0] q;
        wb_rw(1'b0, WB_CTRL, 4'hf, 32'h0, q);
        cmp("ctrl", 32'h1, q);
        wb_rw(1'b0, WB_COUNT, 4'hf, 32'h0, q);
        cmp("count", 32'h0, q);
        wb_rw(1'b0, WB_STATUS, 4'hf, 32'h0, q);
        cmp("status", 32'h0, q);
        wb_rw(1'b1, 8'h0c, 4'hf, 32'hffffffff, q);
        wb_rw(1'b0, 8'h0c, 4'hf, 32'h0, q);
        cmp("unmapped", 32'h0, q);
    endtask
    // First output word must carry the sample of edge one, six edges on
    task automatic test_stream;
        logic [14:0] lo;
        logic last;
        int i, n;
        n = 0;
        last = 1'b0;
        enc_run <= 1'b1;
        for (i = 0; i < 600 && n < 4; i++) begin
            @(posedge clk_i);
            #1;
            if (data_output_clock_o === 1'b1 && last === 1'b0) begin
                if (n == 0) cmp("latency", PIPE_LAT + 1, enc_edges);
                cmp("low half", {7'h7f, 7'h00, 1'b1}, lo);
                cmp("high half", {7'h00, 7'h7f, 1'b0},
                    {chan_a_ddr_pair_o, chan_b_ddr_pair_o, overrange_flag_o});
                n++;
            end
            last = data_output_clock_o;
            lo = {chan_a_ddr_pair_o, chan_b_ddr_pair_o, overrange_flag_o};
        end
        cmp("words", 4, n);
    endtask
    task automatic test_serial;
        logic [7:0] rd;
        logic [31:0] q;
        host_u.xfer({1'b0, MREG_DRIVE, 8'h05}, 16, rd);
        repeat (8) @(posedge clk_i);
        cmp("drive", 32'h5, drive_code_o);
        host_u.xfer({1'b1, MREG_DRIVE, 8'h00}, 16, rd);
        cmp("readback", 32'h5, rd);
        host_u.xfer({1'b0, MREG_SLEEP, 8'h01}, 16, rd);
        host_u.xfer({1'b0, MREG_SLEEP, 8'h00}, 12, rd);
        repeat (8) @(posedge clk_i);
        cmp("sleep kept", 32'h1, sleep_o);
        host_u.xfer({1'b0, MREG_SLEEP, 8'h00}, 16, rd);
        host_u.xfer({1'b0, MREG_DCS, 8'h01}, 16, rd);
        repeat (8) @(posedge clk_i);
        cmp("sleep", 32'h0, sleep_o);
        wb_rw(1'b0, WB_STATUS, 4'hf, 32'h0, q);
        cmp("status", 32'h54, q);
    endtask
    // Output stalled: two buffered plus one pending word, then loss
    task automatic test_stall;
        logic [31:0] q;
        wb_rw(1'b1, WB_CTRL, 4'h1, 32'h0, q);
        repeat (80) @(posedge clk_i);
        wb_rw(1'b0, WB_STATUS, 4'hf, 32'h0, q);
        cmp("lost", 32'h100, q & 32'h100);
        wb_rw(1'b1, WB_CTRL, 4'h1, 32'h1, q);
        repeat (80) @(posedge clk_i);
        wb_rw(1'b1, WB_STATUS, 4'h2, 32'h100, q);
        wb_rw(1'b0, WB_STATUS, 4'hf, 32'h0, q);
        cmp("lost clear", 32'h0, q & 32'h100);
    endtask
    task automatic test_parallel;
        logic [31:0] q;
        int k;
        rst_i <= 1'b1;
        programming_mode_select_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (k = 0; k < 8; k++) begin
            host_u.set_levels(k[2], k[1], k[0]);
            repeat (12) @(posedge clk_i);
            cmp("dcs", 32'(k[2]), dcs_en_o);
            cmp("psleep", 32'(k[1]), sleep_o);
            cmp("pdrive", k[0] ? DRIVE_1P75MA : DRIVE_3P5MA, drive_code_o);
        end
        wb_rw(1'b0, WB_STATUS, 4'hf, 32'h0, q);
        cmp("parallel", 32'h1, q & 32'h1);
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        test_regs();
        test_stream();
        test_serial();
        test_stall();
        test_parallel();
        give_verdict();
    end
endmodule
